/* verilog/ctu_trap_unit.sv */
// Trap entry, marker build and protection checks of the processor
// Summary of operation
// [RULE1] Mode switch pushes external procedure marker plus second status word only.
// [RULE2] Interrupt marker adds sixteen index and six base registers to switch marker.
// [RULE3] Return switch pending bit picks switch or full marker on interrupt exit.
// [RULE4] Mode switch is no trap: no parameter, enters fixed switch object.
// [RULE5] Software gives nil object a data descriptor, bounds one and zero.
// [RULE6] Nil object number is always zero.
// [RULE7] Trace trap parameter is the next instruction address.
// [RULE8] Software never grants write without read; write right implies read.
// [RULE9] Resumed instruction with negative loop count skips, never hangs.
// [RULE10] Faulted multi-word move may restart when no overlap exists.
// [RULE11] Destination register used in source address counts as overlap.
// [RULE12] Native code objects limited to two to the twenty-fourth bytes.
// [RULE13] Wide special read returns code and data segment table descriptors.
// [RULE14] Bounds-aborted byte string reports a contiguous in-bounds byte count.
// [RULE15] Page fault trap reports one eight-byte virtual address.
// [RULE16] Group zero fixes nil, trap, channel, processor and switch objects.
`include "ctu_trap_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module ctu_trap_unit #(
	parameter int WORD_W = 32
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire ctu_trap_pkg::ctu_event_t event_req,
	input wire logic [63:0] next_pc,
	input wire logic [63:0] fault_va,
	input wire ctu_trap_pkg::ctu_cpu_state_t cpu_state,
	input wire logic interrupt_exit_instruction_req,
	input wire ctu_trap_pkg::ctu_access_t access_req,
	input wire ctu_trap_pkg::ctu_move_t move_req,
	input wire logic loop_resume,
	input wire logic signed [31:0] loop_count,
	input wire logic [31:0] code_len,
	input wire logic [1:0] sp_sel,
	input wire logic [63:0] cst_desc,
	input wire logic [63:0] dst_desc,
	input wire ctu_trap_pkg::ctu_string_t string_req,
	output logic busy,
	output logic push_valid,
	output logic [31:0] push_data,
	output logic pop_valid,
	output logic restore_full,
	output logic entry_valid,
	output logic [7:0] entry_obj,
	output logic [63:0] entry_param,
	output logic entry_has_param,
	output logic return_switch_pending_bit,
	output logic access_fault,
	output logic move_overlap,
	output logic move_restart_ok,
	output logic loop_skip,
	output logic code_size_fault,
	output logic [63:0] sp_data,
	output logic [31:0] string_done_count
);
	import ctu_trap_pkg::*;

	// ************************************************
	// Parameter check
	// ************************************************
	if (WORD_W != 32) begin : g_bad_width
		$error("ctu_trap_unit: marker words must be 32 bits");
	end

	// ************************************************
	// Marker sequencer
	// ************************************************
	ctu_state_t state_reg, state_next;
	logic [4:0] idx_reg, idx_next;
	logic [4:0] last_reg, last_next;
	logic [7:0] obj_reg, obj_next;
	logic [63:0] param_reg, param_next;
	logic has_param_reg, has_param_next;
	logic rsp_reg, rsp_next;
	logic busy_reg, busy_next;
	logic push_valid_reg, push_valid_next;
	logic [31:0] push_data_reg, push_data_next;
	logic pop_valid_reg, pop_valid_next;
	logic full_reg, full_next;
	logic entry_valid_reg, entry_valid_next;
	logic [7:0] entry_obj_reg, entry_obj_next;
	logic [63:0] entry_param_reg, entry_param_next;
	logic entry_has_param_reg, entry_has_param_next;
	ctu_words_t words;
	ctu_cpu_state_t held_reg, held_next;

	assign words = ctu_words_t'(held_reg);

	// Next state; events are only taken while idle, priority fault first
	always_comb begin
		state_next = state_reg;
		idx_next = idx_reg;
		last_next = last_reg;
		obj_next = obj_reg;
		param_next = param_reg;
		has_param_next = has_param_reg;
		rsp_next = rsp_reg;
		held_next = held_reg;
		push_valid_next = 1'b0;
		push_data_next = push_data_reg;
		pop_valid_next = 1'b0;
		full_next = full_reg;
		entry_valid_next = 1'b0;
		entry_obj_next = entry_obj_reg;
		entry_param_next = entry_param_reg;
		entry_has_param_next = entry_has_param_reg;
		case (state_reg)
			ST_IDLE: begin
				idx_next = `CTU_RST_CNT;
				held_next = cpu_state;
				if (event_req.page_fault || event_req.trace || event_req.chan_intr || event_req.proc_intr) begin
					state_next = ST_PUSH;
					last_next = `CTU_INTR_WORDS - 5'h01;
					rsp_next = 1'b0;
					// [RULE16] fixed entry objects
					obj_next = (event_req.page_fault || event_req.trace) ? `CTU_OBJ_TRAP :
						(event_req.chan_intr ? `CTU_OBJ_CHAN_INTR : `CTU_OBJ_PROC_INTR);
					// [RULE15] one wide address
					// [RULE7] next instruction address
					param_next = event_req.page_fault ? fault_va : (event_req.trace ? next_pc : `CTU_RST_WIDE);
					has_param_next = event_req.page_fault || event_req.trace;
				end else if (event_req.mode_switch) begin
					// [RULE1] short switch marker
					// [RULE4] no parameter, switch object
					state_next = ST_PUSH;
					last_next = `CTU_SWITCH_WORDS - 5'h01;
					obj_next = `CTU_OBJ_SWITCH;
					param_next = `CTU_RST_WIDE;
					has_param_next = 1'b0;
					rsp_next = 1'b1;
				end else if (interrupt_exit_instruction_req) begin
					// [RULE3] pending bit sizes the restore
					state_next = ST_POP;
					last_next = rsp_reg ? `CTU_SWITCH_WORDS - 5'h01 : `CTU_INTR_WORDS - 5'h01;
					full_next = ~rsp_reg;
				end
			end
			ST_PUSH: begin
				// [RULE2] full marker walks all 25 words
				push_valid_next = 1'b1;
				push_data_next = words[idx_reg];
				idx_next = idx_reg + 5'h01;
				if (idx_reg == last_reg) begin
					state_next = ST_IDLE;
					entry_valid_next = 1'b1;
					entry_obj_next = obj_reg;
					entry_param_next = param_reg;
					entry_has_param_next = has_param_reg;
				end
			end
			ST_POP: begin
				pop_valid_next = 1'b1;
				idx_next = idx_reg + 5'h01;
				if (idx_reg == last_reg) begin
					// Exit done; the switch return no longer pending
					state_next = ST_IDLE;
					rsp_next = 1'b0;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
		busy_next = (state_next != ST_IDLE);
	end

	// Sequencer registers
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= ST_IDLE;
			idx_reg <= `CTU_RST_CNT;
			last_reg <= `CTU_RST_CNT;
			obj_reg <= `CTU_OBJ_NIL;
			param_reg <= `CTU_RST_WIDE;
			has_param_reg <= 1'b0;
			rsp_reg <= 1'b0;
			held_reg <= '0;
			busy_reg <= 1'b0;
			push_valid_reg <= 1'b0;
			push_data_reg <= `CTU_RST_WORD;
			pop_valid_reg <= 1'b0;
			full_reg <= 1'b0;
			entry_valid_reg <= 1'b0;
			entry_obj_reg <= `CTU_OBJ_NIL;
			entry_param_reg <= `CTU_RST_WIDE;
			entry_has_param_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			idx_reg <= idx_next;
			last_reg <= last_next;
			obj_reg <= obj_next;
			param_reg <= param_next;
			has_param_reg <= has_param_next;
			rsp_reg <= rsp_next;
			held_reg <= held_next;
			busy_reg <= busy_next;
			push_valid_reg <= push_valid_next;
			push_data_reg <= push_data_next;
			pop_valid_reg <= pop_valid_next;
			full_reg <= full_next;
			entry_valid_reg <= entry_valid_next;
			entry_obj_reg <= entry_obj_next;
			entry_param_reg <= entry_param_next;
			entry_has_param_reg <= entry_has_param_next;
		end
	end

	// ************************************************
	// Protection and restart checks
	// ************************************************
	logic access_fault_reg, access_fault_next;
	logic overlap_reg, overlap_next;
	logic restart_reg, restart_next;
	logic skip_reg, skip_next;
	logic code_fault_reg, code_fault_next;
	logic [63:0] sp_data_reg, sp_data_next;
	logic [31:0] str_cnt_reg, str_cnt_next;
	logic [32:0] str_room;

	// Check results, one cycle after the request
	always_comb begin
		// [RULE8] write right implies read
		// [RULE5] nil descriptor bounds trap every access
		access_fault_next = access_req.valid &&
			((access_req.write ? !access_req.wr_right : !(access_req.rd_right || access_req.wr_right)) ||
			(access_req.offset < access_req.lower) || (access_req.offset > access_req.upper));
		// [RULE11] address registers count as overlap
		overlap_next = move_req.valid &&
			(((move_req.dst_lo <= move_req.src_hi) && (move_req.src_lo <= move_req.dst_hi)) ||
			(move_req.dst_is_reg && ((move_req.dst_reg == move_req.src_base) ||
			(move_req.dst_reg == move_req.src_index))));
		// [RULE10] restart only without overlap
		restart_next = move_req.valid && move_req.page_fault && !overlap_next;
		// [RULE9] corrupt count skips ahead
		skip_next = loop_resume && loop_count[31];
		// [RULE12] code object size limit
		code_fault_next = code_len > `CTU_CODE_MAX;
		// [RULE13] segment table descriptors
		case (sp_sel)
			`CTU_SP_CST: sp_data_next = cst_desc;
			`CTU_SP_DST: sp_data_next = dst_desc;
			default: sp_data_next = `CTU_RST_WIDE;
		endcase
		// [RULE14] contiguous bytes inside bounds
		str_room = {1'b0, string_req.upper} - {1'b0, string_req.start} + 33'h0_0000_0001;
		str_cnt_next = (!string_req.valid || string_req.start > string_req.upper) ? `CTU_RST_WORD :
			(({1'b0, string_req.len} < str_room) ? string_req.len : str_room[31:0]);
	end

	// Check registers
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			access_fault_reg <= 1'b0;
			overlap_reg <= 1'b0;
			restart_reg <= 1'b0;
			skip_reg <= 1'b0;
			code_fault_reg <= 1'b0;
			sp_data_reg <= `CTU_RST_WIDE;
			str_cnt_reg <= `CTU_RST_WORD;
		end else begin
			access_fault_reg <= access_fault_next;
			overlap_reg <= overlap_next;
			restart_reg <= restart_next;
			skip_reg <= skip_next;
			code_fault_reg <= code_fault_next;
			sp_data_reg <= sp_data_next;
			str_cnt_reg <= str_cnt_next;
		end
	end

	// ************************************************
	// Outputs, all straight from flip-flops
	// ************************************************
	assign busy = busy_reg;
	assign push_valid = push_valid_reg;
	assign push_data = push_data_reg;
	assign pop_valid = pop_valid_reg;
	assign restore_full = full_reg;
	assign entry_valid = entry_valid_reg;
	assign entry_obj = entry_obj_reg;
	assign entry_param = entry_param_reg;
	assign entry_has_param = entry_has_param_reg;
	assign return_switch_pending_bit = rsp_reg;
	assign access_fault = access_fault_reg;
	assign move_overlap = overlap_reg;
	assign move_restart_ok = restart_reg;
	assign loop_skip = skip_reg;
	assign code_size_fault = code_fault_reg;
	assign sp_data = sp_data_reg;
	assign string_done_count = str_cnt_reg;

endmodule // ctu_trap_unit

`default_nettype wire

/* inc/ctu_trap_regs.svh */
// Constants for the trap, marker and protection unit
`ifndef CTU_TRAP_REGS_SVH
`define CTU_TRAP_REGS_SVH

// Fixed objects of group zero
`define CTU_OBJ_NIL 8'h00
`define CTU_OBJ_TRAP 8'h0a
`define CTU_OBJ_CHAN_INTR 8'h0b
`define CTU_OBJ_PROC_INTR 8'h0c
`define CTU_OBJ_SWITCH 8'h0d

// Marker layout in words, pushed from index zero upward
`define CTU_EPM_WORDS 5'h02
`define CTU_STATUS_WORDS 5'h01
`define CTU_INDEX_WORDS 5'h10
`define CTU_BASE_WORDS 5'h06
`define CTU_SWITCH_WORDS 5'h03
`define CTU_INTR_WORDS 5'h19

// Largest native code object in bytes
`define CTU_CODE_MAX 32'h0100_0000

// Wide special read selectors
`define CTU_SP_CST 2'h0
`define CTU_SP_DST 2'h1

// Reset values
`define CTU_RST_WORD 32'h0000_0000
`define CTU_RST_WIDE 64'h0000_0000_0000_0000
`define CTU_RST_CNT 5'h00

`endif

/* inc/ctu_trap_pkg.sv */
// Types for the trap, marker and protection unit
package ctu_trap_pkg;

	// Event requests, one cycle pulses
	typedef struct packed {
		logic mode_switch;
		logic proc_intr;
		logic chan_intr;
		logic trace;
		logic page_fault;
	} ctu_event_t;

	// Processor state captured in a marker; epm lands in the low words
	typedef struct packed {
		logic [5:0][31:0] base_register_set;
		logic [15:0][31:0] index_register_set;
		logic [31:0] second_status_word;
		logic [1:0][31:0] epm;
	} ctu_cpu_state_t;

	typedef logic [24:0][31:0] ctu_words_t;

	// Data object access check
	typedef struct packed {
		logic valid;
		logic write;
		logic rd_right;
		logic wr_right;
		logic [31:0] offset;
		logic [31:0] lower;
		logic [31:0] upper;
	} ctu_access_t;

	// Multi-word move restart check
	typedef struct packed {
		logic valid;
		logic page_fault;
		logic dst_is_reg;
		logic [4:0] dst_reg;
		logic [4:0] src_base;
		logic [4:0] src_index;
		logic [31:0] dst_lo;
		logic [31:0] dst_hi;
		logic [31:0] src_lo;
		logic [31:0] src_hi;
	} ctu_move_t;

	// Byte string bounds abort
	typedef struct packed {
		logic valid;
		logic [31:0] start;
		logic [31:0] len;
		logic [31:0] upper;
	} ctu_string_t;

	typedef enum logic [1:0] {ST_IDLE, ST_PUSH, ST_POP} ctu_state_t;

endpackage

/* sim/ctu_trap_properties.sv */
// Port level checker for the trap, marker and protection unit
`include "ctu_trap_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module ctu_trap_properties (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire ctu_trap_pkg::ctu_event_t event_req,
	input wire logic [63:0] next_pc,
	input wire logic [63:0] fault_va,
	input wire logic interrupt_exit_instruction_req,
	input wire ctu_trap_pkg::ctu_access_t access_req,
	input wire logic loop_resume,
	input wire logic signed [31:0] loop_count,
	input wire logic [31:0] code_len,
	input wire logic busy,
	input wire logic push_valid,
	input wire logic pop_valid,
	input wire logic restore_full,
	input wire logic entry_valid,
	input wire logic [7:0] entry_obj,
	input wire logic [63:0] entry_param,
	input wire logic entry_has_param,
	input wire logic return_switch_pending_bit,
	input wire logic access_fault,
	input wire logic loop_skip,
	input wire logic code_size_fault
);
	import ctu_trap_pkg::*;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	// Requests taken by the idle sequencer, by winning priority
	wire logic take_sw = !busy && event_req == 5'h10;
	wire logic take_pi = !busy && event_req == 5'h08;
	wire logic take_tr = !busy && event_req.trace && !event_req.page_fault;
	wire logic take_pf = !busy && event_req.page_fault;
	wire logic take_ex = !busy && event_req == 5'h00 && interrupt_exit_instruction_req;

	// Short marker, exactly three words then silence
	sequence s_push3;
		push_valid[*3] ##1 !push_valid;
	endsequence
	sequence s_pop3;
		(pop_valid && !restore_full)[*3] ##1 !pop_valid;
	endsequence

	a_switch_marker: assert property (take_sw |-> ##2 s_push3)
		else $error("switch marker length wrong");
	a_switch_entry: assert property (take_sw |-> ##4 entry_valid
		&& entry_obj == `CTU_OBJ_SWITCH && !entry_has_param)
		else $error("switch entry wrong");
	a_switch_pending: assert property (take_sw |=> return_switch_pending_bit)
		else $error("pending bit not set");
	a_intr_marker: assert property (take_pi |-> ##2 push_valid ##24
		(push_valid && entry_valid && entry_obj == `CTU_OBJ_PROC_INTR) ##1 !push_valid)
		else $error("interrupt marker wrong");
	a_trace_param: assert property (take_tr |-> ##26 entry_valid && entry_param == $past(next_pc, 26))
		else $error("trace parameter wrong");
	a_fault_param: assert property (take_pf |-> ##26 entry_valid && entry_obj == `CTU_OBJ_TRAP
		&& entry_param == $past(fault_va, 26))
		else $error("page fault parameter wrong");
	a_exit_switch: assert property (take_ex && return_switch_pending_bit |=> ##1 s_pop3)
		else $error("switch exit wrong");
	a_exit_full: assert property (take_ex && !return_switch_pending_bit |=> ##1 pop_valid ##24
		(pop_valid && restore_full) ##1 !pop_valid)
		else $error("full exit wrong");
	a_nil_fault: assert property (access_req.valid && access_req.lower > access_req.upper
		|=> access_fault)
		else $error("empty bounds not faulted");
	a_write_right: assert property (access_req.valid && access_req.write && !access_req.wr_right
		|=> access_fault)
		else $error("write without right passed");
	a_loop_skip: assert property (loop_resume && loop_count < 0 |=> loop_skip)
		else $error("corrupt loop not skipped");
	a_code_limit: assert property (1'b1 |=> code_size_fault == ($past(code_len) > `CTU_CODE_MAX))
		else $error("code size check wrong");
endmodule // ctu_trap_properties

bind ctu_trap_unit ctu_trap_properties chk_u (.clk_sys(clk_sys), .rst_b(rst_b), .event_req(event_req),
	.next_pc(next_pc), .fault_va(fault_va), .interrupt_exit_instruction_req(interrupt_exit_instruction_req), .access_req(access_req),
	.loop_resume(loop_resume), .loop_count(loop_count), .code_len(code_len), .busy(busy),
	.push_valid(push_valid), .pop_valid(pop_valid), .restore_full(restore_full), .entry_valid(entry_valid),
	.entry_obj(entry_obj), .entry_param(entry_param), .entry_has_param(entry_has_param),
	.return_switch_pending_bit(return_switch_pending_bit), .access_fault(access_fault),
	.loop_skip(loop_skip), .code_size_fault(code_size_fault));
`default_nettype wire

/* sim/ctu_trap_unit_tb.sv */
// Self-checking bench for the trap, marker and protection unit
`include "ctu_trap_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module ctu_trap_unit_tb;
	import ctu_trap_pkg::*;

	logic clk_sys, rst_b, interrupt_exit_instruction_req, loop_resume, busy, push_valid, pop_valid, restore_full;
	logic entry_valid, entry_has_param, return_switch_pending_bit, access_fault, move_overlap;
	logic move_restart_ok, loop_skip, code_size_fault;
	ctu_event_t event_req;
	ctu_cpu_state_t cpu_state;
	ctu_access_t access_req;
	ctu_move_t move_req;
	ctu_string_t string_req;
	logic signed [31:0] loop_count;
	logic [63:0] next_pc, fault_va, cst_desc, dst_desc, sp_data, entry_param, epar;
	logic [31:0] code_len, push_data, string_done_count, r, cnt;
	logic [31:0] seed = 32'h0000_000b;
	logic [31:0] pushq[$];
	logic [7:0] entry_obj, eobj;
	logic [1:0] sp_sel;
	logic ehas, ov;
	int failures = 0, checks = 0, pops, got;

	ctu_trap_unit dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .event_req(event_req), .next_pc(next_pc),
		.fault_va(fault_va), .cpu_state(cpu_state), .interrupt_exit_instruction_req(interrupt_exit_instruction_req), .access_req(access_req),
		.move_req(move_req), .loop_resume(loop_resume), .loop_count(loop_count), .code_len(code_len),
		.sp_sel(sp_sel), .cst_desc(cst_desc), .dst_desc(dst_desc), .string_req(string_req), .busy(busy),
		.push_valid(push_valid), .push_data(push_data), .pop_valid(pop_valid), .restore_full(restore_full),
		.entry_valid(entry_valid), .entry_obj(entry_obj), .entry_param(entry_param),
		.entry_has_param(entry_has_param), .return_switch_pending_bit(return_switch_pending_bit),
		.access_fault(access_fault), .move_overlap(move_overlap), .move_restart_ok(move_restart_ok),
		.loop_skip(loop_skip), .code_size_fault(code_size_fault), .sp_data(sp_data),
		.string_done_count(string_done_count));

	// 40 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	// Xorshift source, fixed start so runs repeat
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Byte count of an aborted string, never past the bound
	function automatic logic [31:0] exp_count(ctu_string_t s);
		if (s.start > s.upper) return 32'h0;
		return (s.len < s.upper - s.start + 1) ? s.len : s.upper - s.start + 1;
	endfunction

	// Bounds inclusive; write right alone is enough for reads
	function automatic logic exp_fault(ctu_access_t a);
		return a.offset < a.lower || a.offset > a.upper || (a.write ? !a.wr_right : !(a.rd_right | a.wr_right));
	endfunction

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		if (failures == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// Sampled before the edge's own updates land, so values are settled
	always @(posedge clk_sys) begin
		if (push_valid === 1'b1) pushq.push_back(push_data);
		if (pop_valid === 1'b1) pops++;
		if (entry_valid === 1'b1) begin
			got = 1;
			eobj = entry_obj;
			epar = entry_param;
			ehas = entry_has_param;
		end
	end

	// One event through to its entry; has of x leaves the flag unchecked
	task automatic run_ev(input ctu_event_t ev, input logic [7:0] obj, input int n, input logic [63:0] par,
		input logic has);
		ctu_words_t w;
		for (int i = 0; i < 25; i++) w[i] = xs();
		pushq.delete();
		got = 0;
		cpu_state = ctu_cpu_state_t'(w);
		event_req = ev;
		@(negedge clk_sys);
		event_req = '0;
		check(busy, 1'b1);
		for (int i = 0; i < 40 && got == 0; i++) @(negedge clk_sys);
		check(busy, 1'b0);
		check(64'(pushq.size()), 64'(n));
		for (int i = 0; i < n; i++) check(pushq[i], w[i]);
		check(eobj, obj);
		if (has !== 1'bx) check(ehas, has);
		if (has === 1'b1) check(epar, par);
	endtask

	task automatic run_exit(input int n, input logic full);
		pops = 0;
		interrupt_exit_instruction_req = 1'b1;
		@(negedge clk_sys);
		interrupt_exit_instruction_req = 1'b0;
		for (int i = 0; i < 40 && busy !== 1'b0; i++) @(negedge clk_sys);
		repeat (2) @(negedge clk_sys);
		check(64'(pops), 64'(n));
		check(restore_full, full);
		check(return_switch_pending_bit, 1'b0);
	endtask

	// Watchdog far beyond the expected run length
	initial begin
		#(25 * 30000);
		failures++;
		complete_run();
	end

	// **********************************************
	// Main sequence
	// **********************************************
	initial begin
		rst_b = 1'b0;
		{event_req, interrupt_exit_instruction_req, cpu_state, next_pc, fault_va, access_req, move_req} = '0;
		{loop_resume, loop_count, code_len, sp_sel, cst_desc, dst_desc, string_req} = '0;
		repeat (8) @(negedge clk_sys);
		rst_b = 1'b1;
		@(negedge clk_sys);
		next_pc = {xs(), xs()};
		fault_va = {xs(), xs()};
		run_ev(5'h10, `CTU_OBJ_SWITCH, 3, 64'h0, 1'b0);
		check(return_switch_pending_bit, 1'b1);
		run_exit(3, 1'b0);
		run_ev(5'h01, `CTU_OBJ_TRAP, 25, fault_va, 1'b1);
		run_ev(5'h02, `CTU_OBJ_TRAP, 25, next_pc, 1'b1);
		run_ev(5'h04, `CTU_OBJ_CHAN_INTR, 25, 64'h0, 1'b0);
		run_ev(5'h10, `CTU_OBJ_SWITCH, 3, 64'h0, 1'b0);
		run_ev(5'h08, `CTU_OBJ_PROC_INTR, 25, 64'h0, 1'b0);
		run_ev(5'h1f, `CTU_OBJ_TRAP, 25, fault_va, 1'b1);
		run_exit(25, 1'b1);
		// Random checks; the first few passes are forced corners
		for (int i = 0; i < 300; i++) begin
			r = xs();
			access_req = '{1'b1, r[0], r[1] | r[2], r[2], xs() & 32'hff, xs() & 32'hff, xs() & 32'hff};
			if (i == 0) access_req = '{1'b1, r[0], 1'b1, 1'b1, 32'h0, 32'h1, 32'h0};
			loop_resume = r[3];
			loop_count = (i == 1) ? -32'sd1 : (i == 2) ? 32'sd0 : xs();
			code_len = 32'h00ff_fff0 + (xs() & 32'h1f);
			sp_sel = r[5:4];
			cst_desc = {xs(), xs()};
			dst_desc = {xs(), xs()};
			move_req = '{1'b1, r[6], r[7], r[12:8], r[17:13], r[22:18], 32'h0, 32'h0, xs() & 32'hff, 32'h0};
			move_req.src_hi = move_req.src_lo + (xs() & 32'hf);
			move_req.dst_lo = r[7] ? 32'hffff_0000 : xs() & 32'hff;
			move_req.dst_hi = move_req.dst_lo + (xs() & 32'hf);
			if (i == 3) begin
				move_req.dst_is_reg = 1'b1;
				move_req.dst_reg = move_req.src_index;
				move_req.dst_lo = 32'hffff_0000;
				move_req.dst_hi = 32'hffff_0000;
			end
			string_req = '{1'b1, xs() & 32'hff, xs() & 32'hff, xs() & 32'hff};
			@(negedge clk_sys);
			ov = move_req.dst_is_reg ? (move_req.dst_reg == move_req.src_base || move_req.dst_reg == move_req.src_index)
				: !(move_req.dst_hi < move_req.src_lo || move_req.src_hi < move_req.dst_lo);
			cnt = exp_count(string_req);
			check(access_fault, exp_fault(access_req));
			check(loop_skip, loop_resume && loop_count < 0);
			check(code_size_fault, code_len > `CTU_CODE_MAX);
			check(sp_data, (sp_sel == `CTU_SP_CST) ? cst_desc : (sp_sel == `CTU_SP_DST) ? dst_desc : 64'h0);
			check(move_overlap, ov);
			if (move_req.page_fault) check(move_restart_ok, !ov);
			check(string_done_count, cnt);
		end
		complete_run();
	end
endmodule // ctu_trap_unit_tb
`default_nettype wire
